//--- hdl/bsc_boundary_chain.sv
// Boundary scan register of 54 cells with update hand-off to the core clock
`timescale 1ns/1ns
`default_nettype none
`include "bsc_consts.svh"
module bsc_boundary_chain (
  input wire logic clk,
  input wire logic resetn,
  input wire logic tck,
  input wire logic tap_resetn,
  input wire logic tdi,
  output logic tdo,
  input wire logic capture_dr,
  input wire logic shift_dr,
  input wire logic update_dr,
  input wire logic instr_sample,
  input wire logic instr_extest,
  input wire bsc_pkg::bsc_inonly_s in_pins,
  input wire bsc_pkg::bsc_outonly_s core_outonly,
  input wire bsc_pkg::bsc_bidir_s core_bidir_out,
  input wire bsc_pkg::bsc_ctl_s core_ctl,
  output bsc_pkg::bsc_outonly_s outonly_o,
  input wire bsc_pkg::bsc_bidir_s bidir_i,
  output bsc_pkg::bsc_bidir_s bidir_o,
  output bsc_pkg::bsc_bidir_s bidir_oe,
  output logic upd_valid,
  input wire logic upd_ready,
  output bsc_pkg::bsc_chain_t upd_data
);
  import bsc_pkg::*;

  localparam logic [10:0][5:0] GRPA_MAP = `BSC_GRPA_MAP;
  localparam logic [4:0][5:0] GRPB_MAP = `BSC_GRPB_MAP;

  typedef struct packed {
    bsc_obs_s obs_s1;
    bsc_obs_s obs_s2;
    bsc_chain_t sr;
    bsc_chain_t upd;
    bsc_chain_t xfer;
    logic req_tgl;
    logic ack_s1;
    logic ack_s2;
  } bsc_tck_state_s;

  typedef struct packed {
    logic req_s1;
    logic req_s2;
    logic req_s3;
    logic ack_tgl;
    logic pend;
  } bsc_clk_state_s;

  bsc_tck_state_s tst_reg, tst_next;
  bsc_clk_state_s cst_reg, cst_next;
  bsc_obs_s obs_now;
  bsc_chain_t cap;
  bsc_ctl_s drv_ctl;
  logic load_en;
  logic fifo_in_ready;

  // Pin drive: boundary values under extest, core values otherwise
  always_comb begin
    outonly_o = core_outonly;
    bidir_o = core_bidir_out;
    drv_ctl = core_ctl;
    if (instr_extest) begin
      outonly_o.downstream_reset_out[0] = tst_reg.upd[`BSC_DSR_CELL0];
      outonly_o.downstream_reset_out[1] = tst_reg.upd[`BSC_DSR_CELL1];
      outonly_o.eeprom_serial_clock = tst_reg.upd[`BSC_EE_CLOCK_CELL];
      for (int i = 0; i < 11; i++) begin
        bidir_o.grp_a[i] = tst_reg.upd[GRPA_MAP[i]];
      end
      drv_ctl.grp_a = tst_reg.upd[`BSC_GRPA_CTL];
      for (int i = 0; i < `BSC_GPIO_COUNT; i++) begin
        bidir_o.gpio[i] = tst_reg.upd[`BSC_GPIO_BASE + 2*i];
        drv_ctl.gpio[i] = tst_reg.upd[`BSC_GPIO_BASE + 2*i + 1];
      end
      for (int i = 0; i < 5; i++) begin
        bidir_o.grp_b[i] = tst_reg.upd[GRPB_MAP[i]];
      end
      drv_ctl.grp_b = tst_reg.upd[`BSC_GRPB_CTL];
      bidir_o.eeprom_serial_data = tst_reg.upd[`BSC_EEDATA_CELL];
      drv_ctl.eeprom = tst_reg.upd[`BSC_EECTL_CELL];
    end
    bidir_oe.grp_a = {11{drv_ctl.grp_a}};
    bidir_oe.gpio = drv_ctl.gpio;
    bidir_oe.grp_b = {5{drv_ctl.grp_b}};
    bidir_oe.eeprom_serial_data = drv_ctl.eeprom;
  end

  // What the capture cells observe, before synchronising onto tck
  always_comb begin
    obs_now.inonly = in_pins;
    obs_now.bidir_in = bidir_i;
    obs_now.outonly = outonly_o;
    obs_now.bidir_out = bidir_o;
    obs_now.ctl = drv_ctl;
  end

  // Parallel capture image; internal cells keep their fixed value
  always_comb begin
    cap = {`BSC_CELL_COUNT{`BSC_INTERNAL_VALUE}};
    cap[`BSC_DSR_CELL0] = tst_reg.obs_s2.outonly.downstream_reset_out[0];
    cap[`BSC_DSR_CELL1] = tst_reg.obs_s2.outonly.downstream_reset_out[1];
    cap[`BSC_TEST1_CELL] = tst_reg.obs_s2.inonly.test_in1;
    cap[`BSC_FRST_CELL] = tst_reg.obs_s2.inonly.fundamental_reset_in;
    cap[`BSC_TEST2_CELL] = tst_reg.obs_s2.inonly.test_in2;
    for (int i = 0; i < 11; i++) begin
      cap[GRPA_MAP[i]] = tst_reg.obs_s2.bidir_in.grp_a[i];
    end
    cap[`BSC_GRPA_CTL] = tst_reg.obs_s2.ctl.grp_a;
    for (int i = 0; i < `BSC_GPIO_COUNT; i++) begin
      cap[`BSC_GPIO_BASE + 2*i] = tst_reg.obs_s2.bidir_in.gpio[i];
      cap[`BSC_GPIO_BASE + 2*i + 1] = tst_reg.obs_s2.ctl.gpio[i];
    end
    for (int i = 0; i < 5; i++) begin
      cap[GRPB_MAP[i]] = tst_reg.obs_s2.bidir_in.grp_b[i];
    end
    cap[`BSC_GRPB_CTL] = tst_reg.obs_s2.ctl.grp_b;
    cap[`BSC_EE_CLOCK_CELL] = tst_reg.obs_s2.outonly.eeprom_serial_clock;
    cap[`BSC_EEDATA_CELL] = tst_reg.obs_s2.bidir_in.eeprom_serial_data;
    cap[`BSC_EECTL_CELL] = tst_reg.obs_s2.ctl.eeprom;
  end

  assign load_en = capture_dr && (instr_sample || instr_extest);
  assign tdo = tst_reg.sr[0];

  // Test clock domain: chain, update latch, request side of hand-off
  always_comb begin
    tst_next = tst_reg;
    tst_next.obs_s1 = obs_now;
    tst_next.obs_s2 = tst_reg.obs_s1;
    tst_next.ack_s1 = cst_reg.ack_tgl;
    tst_next.ack_s2 = tst_reg.ack_s1;
    if (load_en) begin
      tst_next.sr = cap;
    end else if (shift_dr) begin
      tst_next.sr = {tdi, tst_reg.sr[`BSC_CELL_COUNT-1:1]};
    end
    if (update_dr) begin
      tst_next.upd = tst_reg.sr;
      // Only hand off when the previous word has been taken
      if (tst_reg.req_tgl == tst_reg.ack_s2) begin
        tst_next.xfer = tst_reg.sr;
        tst_next.req_tgl = !tst_reg.req_tgl;
      end
    end
  end

  always_ff @(posedge tck) begin
    if (!tap_resetn) begin
      tst_reg <= '0;
    end else begin
      tst_reg <= tst_next;
    end
  end

  // Core clock domain: receive side, held until the buffer has room
  always_comb begin
    cst_next = cst_reg;
    cst_next.req_s1 = tst_reg.req_tgl;
    cst_next.req_s2 = cst_reg.req_s1;
    cst_next.req_s3 = cst_reg.req_s2;
    if (cst_reg.req_s2 != cst_reg.req_s3) begin
      cst_next.pend = 1'b1;
    end
    if (cst_reg.pend && fifo_in_ready) begin
      cst_next.pend = 1'b0;
      cst_next.ack_tgl = !cst_reg.ack_tgl;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cst_reg <= '0;
    end else begin
      cst_reg <= cst_next;
    end
  end

  bsc_fifo2 #(
    .WIDTH(`BSC_CELL_COUNT),
    .DEPTH(`BSC_FIFO_DEPTH)
  ) u_upd_fifo (
    .clk(clk),
    .resetn(resetn),
    .in_valid(cst_reg.pend),
    .in_ready(fifo_in_ready),
    .in_data(tst_reg.xfer),
    .out_valid(upd_valid),
    .out_ready(upd_ready),
    .out_data(upd_data)
  );

  sequence s_load;
    load_en;
  endsequence

  sequence s_update_hold;
    update_dr && instr_extest ##1 instr_extest;
  endsequence

  a_shift_path_order: assert property (@(posedge tck) disable iff (!tap_resetn)
    shift_dr && !load_en |=> tst_reg.sr[`BSC_CELL_COUNT-1] == $past(tdi)
      && tst_reg.sr[`BSC_CELL_COUNT-2:0] == $past(tst_reg.sr[`BSC_CELL_COUNT-1:1]))
    else $error("chain did not shift by one cell");
  a_outonly_drive: assert property (@(posedge tck) disable iff (!tap_resetn)
    s_update_hold |-> outonly_o.downstream_reset_out == $past(tst_reg.sr[1:0]))
    else $error("reset outputs not driven from cells 0 and 1");
  a_input_capture: assert property (@(posedge tck) disable iff (!tap_resetn)
    s_load |=> tst_reg.sr[`BSC_FRST_CELL] == $past(tst_reg.obs_s2.inonly.fundamental_reset_in)
      && tst_reg.sr[`BSC_TEST1_CELL] == $past(tst_reg.obs_s2.inonly.test_in1))
    else $error("input cells did not capture pins");
  a_grpa_enable: assert property (@(posedge tck) disable iff (!tap_resetn)
    s_update_hold |-> bidir_oe.grp_a == {11{$past(tst_reg.sr[`BSC_GRPA_CTL])}})
    else $error("group A enable not from cell 12");
  a_gpio_enable: assert property (@(posedge tck) disable iff (!tap_resetn)
    s_update_hold |-> bidir_oe.gpio[0] == $past(tst_reg.sr[20])
      && bidir_oe.gpio[7] == $past(tst_reg.sr[34]) && bidir_o.gpio[7] == $past(tst_reg.sr[33]))
    else $error("gpio drive or enable from wrong cell");
  a_grpb_enable: assert property (@(posedge tck) disable iff (!tap_resetn)
    s_update_hold |-> bidir_oe.grp_b == {5{$past(tst_reg.sr[`BSC_GRPB_CTL])}}
      && bidir_o.grp_b[4] == $past(tst_reg.sr[47]))
    else $error("group B drive or enable wrong");
  a_eeprom_cells: assert property (@(posedge tck) disable iff (!tap_resetn)
    s_update_hold |-> outonly_o.eeprom_serial_clock == $past(tst_reg.sr[51])
      && bidir_oe.eeprom_serial_data == $past(tst_reg.sr[53]))
    else $error("eeprom cells mismatched");
  a_internal_fixed: assert property (@(posedge tck) disable iff (!tap_resetn)
    s_load |=> (tst_reg.sr & `BSC_INTERNAL_MASK) == '0)
    else $error("internal cell captured nonzero");
  a_no_capture_idle: assert property (@(posedge tck) disable iff (!tap_resetn)
    capture_dr && !instr_sample && !instr_extest && !shift_dr |=> $stable(tst_reg.sr))
    else $error("chain loaded without sample or extest");
endmodule
`default_nettype wire

//--- common/bsc_consts.svh
// Constants for the boundary scan chain: cell positions, masks, depths
`ifndef BSC_CONSTS_SVH
`define BSC_CONSTS_SVH
`define BSC_CELL_COUNT 54
`define BSC_DSR_CELL0 0
`define BSC_DSR_CELL1 1
`define BSC_TEST1_CELL 3
`define BSC_FRST_CELL 4
`define BSC_TEST2_CELL 5
`define BSC_GRPA_CTL 12
`define BSC_GRPA_MAP {6'h12, 6'h11, 6'h10, 6'h0F, 6'h0E, 6'h0D, 6'h0B, 6'h09, 6'h08, 6'h07, 6'h06}
`define BSC_GPIO_BASE 19
`define BSC_GPIO_COUNT 8
`define BSC_GRPB_CTL 45
`define BSC_GRPB_MAP {6'h2F, 6'h29, 6'h27, 6'h24, 6'h23}
`define BSC_EE_CLOCK_CELL 51
`define BSC_EEDATA_CELL 52
`define BSC_EECTL_CELL 53
`define BSC_INTERNAL_MASK 54'h075D6000000404
`define BSC_INTERNAL_VALUE 1'b0
`define BSC_FIFO_DEPTH 2
`endif

//--- common/bsc_pkg.sv
// Types for the boundary scan chain
`include "bsc_consts.svh"
package bsc_pkg;
  typedef logic [`BSC_CELL_COUNT-1:0] bsc_chain_t;
  typedef struct packed {
    logic test_in2;
    logic fundamental_reset_in;
    logic test_in1;
  } bsc_inonly_s;
  typedef struct packed {
    logic eeprom_serial_clock;
    logic [1:0] downstream_reset_out;
  } bsc_outonly_s;
  typedef struct packed {
    logic [10:0] grp_a;
    logic [7:0] gpio;
    logic [4:0] grp_b;
    logic eeprom_serial_data;
  } bsc_bidir_s;
  typedef struct packed {
    logic grp_a;
    logic [7:0] gpio;
    logic grp_b;
    logic eeprom;
  } bsc_ctl_s;
  typedef struct packed {
    bsc_inonly_s inonly;
    bsc_bidir_s bidir_in;
    bsc_outonly_s outonly;
    bsc_bidir_s bidir_out;
    bsc_ctl_s ctl;
  } bsc_obs_s;
endpackage

//--- hdl/bsc_fifo2.sv
// Small flop FIFO with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module bsc_fifo2 #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } bsc_fifo_state_s;
  bsc_fifo_state_s st_reg, st_next;
  logic push, pop;

  assign in_ready = (st_reg.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_reg.cnt != '0);
  assign out_data = st_reg.mem[st_reg.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wp] = in_data;
      st_next.wp = (st_reg.wp == AW'(DEPTH-1)) ? '0 : st_reg.wp + 1'b1;
    end
    if (pop) begin
      st_next.rp = (st_reg.rp == AW'(DEPTH-1)) ? '0 : st_reg.rp + 1'b1;
    end
    if (push && !pop) begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end else if (pop && !push) begin
      st_next.cnt = st_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule
`default_nettype wire

//--- sim/bsc_tester.sv
// Behavioural boundary-scan tester driving the test clock and TAP states
`timescale 1ns/1ns
`default_nettype none
module bsc_tester (
  output logic tck,
  output logic tdi,
  output logic capture_dr,
  output logic shift_dr,
  output logic update_dr,
  input wire logic tdo
);
  import bsc_pkg::*;
  initial begin
    tck = 1'b0;
    tdi = 1'b0;
    capture_dr = 1'b0;
    shift_dr = 1'b0;
    update_dr = 1'b0;
  end
  // One test clock period; the clock stands still between calls
  task automatic pulse();
    #80 tck = 1'b1;
    #80 tck = 1'b0;
  endtask
  // Idle periods; serial data keeps changing so no stale bit lingers
  task automatic idle(input int n);
    repeat (n) begin
      tdi = ~tdi;
      pulse();
    end
  endtask
  task automatic frame(input logic cap, input bsc_chain_t din, input logic upd,
                       output bsc_chain_t dout);
    #7 capture_dr = cap;
    if (cap) pulse();
    capture_dr = 1'b0;
    shift_dr = 1'b1;
    for (int i = 0; i < 54; i++) begin
      tdi = din[i];
      #80 dout[i] = tdo;
      tck = 1'b1;
      #80 tck = 1'b0;
    end
    shift_dr = 1'b0;
    tdi = ~tdi;
    update_dr = upd;
    pulse();
    update_dr = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- sim/test_bsc_boundary_chain.sv
// Self-checking bench for the boundary scan chain
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module test_bsc_boundary_chain;
  import bsc_pkg::*;
  logic clk = 1'b0, resetn = 1'b0, tap_resetn = 1'b0, upd_ready = 1'b0, stall = 1'b0;
  logic instr_sample = 1'b0, instr_extest = 1'b0;
  logic tck, tdi, tdo, capture_dr, shift_dr, update_dr, upd_valid;
  bsc_inonly_s in_pins = '0;
  bsc_outonly_s core_outonly = '0, outonly_o, eo;
  bsc_bidir_s core_bidir_out = '0, bidir_i = '0, bidir_o, bidir_oe, eb, ebe;
  bsc_ctl_s core_ctl = '0;
  bsc_chain_t upd_data, w, w2, dout, e, ew;
  bsc_chain_t up = '0;
  bsc_chain_t q[$];
  int miscompares = 0, comparisons = 0;
  always #10 clk = ~clk;
  bsc_tester bsc_tester_inst (.tck, .tdi, .capture_dr, .shift_dr, .update_dr, .tdo);
  bsc_boundary_chain bsc_boundary_chain_inst (.clk, .resetn, .tck, .tap_resetn, .tdi, .tdo,
    .capture_dr, .shift_dr, .update_dr, .instr_sample, .instr_extest, .in_pins,
    .core_outonly, .core_bidir_out, .core_ctl, .outonly_o, .bidir_i, .bidir_o, .bidir_oe,
    .upd_valid, .upd_ready, .upd_data);
  // Full captured image; under external test output-only and enable cells see the update word
  function automatic void cap_exp(input logic ext, input bsc_chain_t u, output bsc_chain_t ex);
    int a[11] = '{6, 7, 8, 9, 11, 13, 14, 15, 16, 17, 18};
    int b[5] = '{35, 36, 39, 41, 47};
    ex = '0;
    ex[1:0] = ext ? u[1:0] : core_outonly.downstream_reset_out;
    ex[5:3] = in_pins;
    ex[12] = ext ? u[12] : core_ctl.grp_a;
    for (int k = 0; k < 11; k++) begin
      ex[a[k]] = bidir_i.grp_a[k];
    end
    for (int i = 0; i < 8; i++) begin
      ex[19 + 2 * i] = bidir_i.gpio[i];
      ex[20 + 2 * i] = ext ? u[20 + 2 * i] : core_ctl.gpio[i];
    end
    for (int k = 0; k < 5; k++) begin
      ex[b[k]] = bidir_i.grp_b[k];
    end
    ex[45] = ext ? u[45] : core_ctl.grp_b;
    ex[51] = ext ? u[51] : core_outonly.eeprom_serial_clock;
    ex[52] = bidir_i.eeprom_serial_data;
    ex[53] = ext ? u[53] : core_ctl.eeprom;
  endfunction
  // Pin drive and enables expected from an update word under external test
  function automatic void pins(input bsc_chain_t u);
    int a[11] = '{6, 7, 8, 9, 11, 13, 14, 15, 16, 17, 18};
    int b[5] = '{35, 36, 39, 41, 47};
    eo = {u[51], u[1], u[0]};
    for (int k = 0; k < 11; k++) begin
      eb.grp_a[k] = u[a[k]];
      ebe.grp_a[k] = u[12];
    end
    for (int i = 0; i < 8; i++) begin
      eb.gpio[i] = u[19 + 2 * i];
      ebe.gpio[i] = u[20 + 2 * i];
    end
    for (int k = 0; k < 5; k++) begin
      eb.grp_b[k] = u[b[k]];
      ebe.grp_b[k] = u[45];
    end
    eb.eeprom_serial_data = u[52];
    ebe.eeprom_serial_data = u[53];
  endfunction
  task automatic close_out();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Sink of the update stream, stalling at random or on demand
  always @(posedge clk) begin
    if (upd_valid === 1'b1 && upd_ready === 1'b1) begin
      ew = q.pop_front();
      `CHK("upd_data", ew, upd_data)
    end
    #1 upd_ready = stall ? 1'b0 : 1'($urandom);
  end
  initial begin
    void'($urandom(75));
    repeat (2) @(posedge clk);
    #1 resetn = 1'b1;
    bsc_tester_inst.idle(3);
    tap_resetn = 1'b1;
    `CHK("tdo_reset", 1'b0, tdo)
    `CHK("valid_reset", 1'b0, upd_valid)
    for (int t = 0; t < 6; t++) begin
      @(posedge clk);
      #1 stall = (t == 2);
      in_pins = 3'($urandom);
      core_outonly = 3'($urandom);
      core_bidir_out = 25'($urandom);
      core_ctl = 11'($urandom);
      bidir_i = 25'($urandom);
      w = (t < 2) ? {54{t[0] == 1'b0}} : 54'({$urandom, $urandom});
      w2 = 54'({$urandom, $urandom});
      instr_sample = !t[0];
      instr_extest = t[0];
      bsc_tester_inst.idle(3);
      cap_exp(t[0], up, e);
      bsc_tester_inst.frame(1'b1, w, 1'b1, dout);
      `CHK("capture", e, dout)
      q.push_back(w);
      instr_sample = 1'b0;
      instr_extest = 1'b1;
      bsc_tester_inst.idle(1);
      pins(w);
      `CHK("outonly", eo, outonly_o)
      `CHK("bidir_o", eb, bidir_o)
      `CHK("bidir_oe", ebe, bidir_oe)
      instr_extest = 1'b0;
      bsc_tester_inst.frame(1'b1, w2, 1'b1, dout);
      `CHK("no_capture", w, dout)
      q.push_back(w2);
      up = w2;
      if (stall) `CHK("stall_valid", 1'b1, upd_valid)
    end
    stall = 1'b0;
    for (int i = 0; i < 400 && q.size() > 0; i++) @(posedge clk);
    `CHK("drained", 0, q.size())
    close_out();
  end
endmodule
`default_nettype wire
